// file: shared/pdme_pkg.sv
// Purpose: Constants shared by the pulse density monitor and enforcer.
// Assumes: One 20 MHz core clock; register port and PCM streams are on it.
// Notes: The density criterion is a sliding window with a minimum ones count.

package pdme_pkg;

   // Register port
   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 8;
   localparam logic [7:0] RX_REG_ADDR = 8'h55;
   localparam logic [7:0] TX_REG_ADDR = 8'h59;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Field positions; bits 0 to 4 in both status registers, bits 5 to 7 transmit only
   localparam int BIT_DENS_EN = 0;
   localparam int BIT_ZERO_EN = 1;
   localparam int BIT_DENS_EV = 2;
   localparam int BIT_ZERO_EV = 3;
   localparam int BIT_LIVE = 4;
   localparam int BIT_FILL_EV = 5;
   localparam int BIT_STUFF_EN = 6;
   localparam int BIT_FILL_EN = 7;

   // Reset values of the enable and event fields
   localparam logic EN_RESET = 1'b0;
   localparam logic EV_RESET = 1'b0;

   // Density criterion and zero-run length
   localparam int DENS_WINDOW = 24;
   localparam logic [4:0] DENS_MIN_ONES = 5'h03;
   localparam int ZRUN_W = 5;
   localparam logic [4:0] ZERO_RUN_LEN = 5'h10;

   // Transmit buffer shape
   localparam int TX_FIFO_WIDTH = 1;
   localparam int TX_FIFO_DEPTH = 8;

endpackage

// file: hdl/bit_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty derive from an occupancy count, so any depth works.
`timescale 1ns/1ps
`default_nettype none

module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import pdme_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } fifo_state_t;

   fifo_state_t s_q, s_d;
   logic push, pop;

   // Honest flags straight from occupancy
   assign in_ready = (s_q.count != CW'(DEPTH));
   assign out_valid = (s_q.count != '0);
   assign out_data = s_q.mem[s_q.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer wrap written out so non power-of-two depths stay legal
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr_ptr] = in_data;
         s_d.wr_ptr = (s_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : s_q.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_d.rd_ptr = (s_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : s_q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         s_d.count = s_q.count + 1'b1;
      end else if (pop && !push) begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

`default_nettype wire

// file: hdl/pulse_density_monitor_enforcer.sv
// Purpose: Receive density detector and transmit density enforcer with status.
// Assumes: Register strobes and PCM streams are synchronous to core_clk.
// Notes: A violation is fewer than DENS_MIN_ONES ones in the last DENS_WINDOW bits.
`timescale 1ns/1ps
`default_nettype none

module pulse_density_monitor_enforcer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Microprocessor register port
   input wire logic reg_sel,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [pdme_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [pdme_pkg::REG_DATA_W-1:0] reg_wdata,
   output logic [pdme_pkg::REG_DATA_W-1:0] reg_rdata,
   output logic reg_rdata_valid,
   output logic irq_n,
   // Receive PCM bit stream to supervise
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   // Transmit PCM bit stream into the enforcer
   input wire logic tx_in_bit,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   // Transmit PCM bit stream out of the enforcer
   output logic tx_out_bit,
   output logic tx_out_valid,
   input wire logic tx_out_ready
);
   import pdme_pkg::*;

   typedef logic [DENS_WINDOW-1:0] window_t;

   typedef struct packed {
      // Receive detector
      window_t rx_win;
      logic [ZRUN_W-1:0] rx_zeros;
      logic rx_live;
      logic rx_dens_ev;
      logic rx_zero_ev;
      logic rx_dens_en;
      logic rx_zero_en;
      // Transmit enforcer
      window_t tx_win;
      logic [ZRUN_W-1:0] tx_zeros;
      logic tx_live;
      logic tx_dens_ev;
      logic tx_zero_ev;
      logic tx_fill_ev;
      logic tx_dens_en;
      logic tx_zero_en;
      logic tx_fill_en;
      logic tx_stuff_en;
      logic out_bit;
      logic out_valid;
      // Register port answer and interrupt
      logic [REG_DATA_W-1:0] rdata;
      logic rvalid;
      logic irq;
   } state_t;

   state_t s_q, s_d;

   // FIFO drain side
   logic fifo_valid;
   logic fifo_ready;
   logic [TX_FIFO_WIDTH-1:0] fifo_data;

   // Combinational helpers
   window_t rx_next_win, tx_cand_win, tx_next_win;
   logic rx_next_live, tx_cand_viol, tx_next_live;
   logic tx_take, tx_bit_sent, tx_stuffing;
   logic [ZRUN_W-1:0] rx_next_zeros, tx_next_zeros;
   logic rx_run_hit, tx_run_hit;
   logic rd_rx, rd_tx, wr_rx, wr_tx;
   logic [REG_DATA_W-1:0] rx_image, tx_image;
   logic irq_rx, irq_tx;

   // Ones count of a window
   function automatic logic [4:0] count_ones(input window_t w);
      logic [4:0] n;
      n = '0;
      for (int i = 0; i < DENS_WINDOW; i++) begin
         n = n + 5'(w[i]);
      end
      return n;
   endfunction

   // Density criterion, shared by detector and enforcer
   function automatic logic violates(input window_t w);
      return count_ones(w) < DENS_MIN_ONES;
   endfunction

   // Zero-run counter step; saturates at the run length
   function automatic logic [ZRUN_W-1:0] zrun_step(input logic [ZRUN_W-1:0] z,
                                                   input logic b);
      logic [ZRUN_W-1:0] r;
      r = z;
      if (b) begin
         r = '0;
      end else if (z != ZERO_RUN_LEN) begin
         r = z + 1'b1;
      end
      return r;
   endfunction

   // Transmit buffer; full FIFO drops tx_in_ready so the source stalls
   bit_fifo #(
      .WIDTH(TX_FIFO_WIDTH),
      .DEPTH(TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .in_data(tx_in_bit),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // Register port decode
   assign rd_rx = reg_sel && reg_rd && (reg_addr == RX_REG_ADDR);
   assign rd_tx = reg_sel && reg_rd && (reg_addr == TX_REG_ADDR);
   assign wr_rx = reg_sel && reg_wr && (reg_addr == RX_REG_ADDR);
   assign wr_tx = reg_sel && reg_wr && (reg_addr == TX_REG_ADDR);

   // Receive detector: window and run length after the incoming bit
   assign rx_next_win = {s_q.rx_win[DENS_WINDOW-2:0], rx_bit};
   assign rx_next_live = violates(rx_next_win);
   assign rx_next_zeros = zrun_step(s_q.rx_zeros, rx_bit);
   assign rx_run_hit = (rx_next_zeros == ZERO_RUN_LEN) && (s_q.rx_zeros != ZERO_RUN_LEN);

   // Enforcer: a bit leaves when the output slot is free or being taken
   assign tx_take = !s_q.out_valid || tx_out_ready;
   assign fifo_ready = tx_take;
   assign tx_stuffing = s_q.tx_stuff_en;
   assign tx_cand_win = {s_q.tx_win[DENS_WINDOW-2:0], fifo_data[0]};
   assign tx_cand_viol = violates(tx_cand_win);
   // Forcing a one restores the count lost by the dropped oldest bit
   assign tx_bit_sent = (tx_stuffing && tx_cand_viol) ? 1'b1 : fifo_data[0];
   assign tx_next_win = {s_q.tx_win[DENS_WINDOW-2:0], tx_bit_sent};
   assign tx_next_live = violates(tx_next_win);
   assign tx_next_zeros = zrun_step(s_q.tx_zeros, tx_bit_sent);
   assign tx_run_hit = (tx_next_zeros == ZERO_RUN_LEN) && (s_q.tx_zeros != ZERO_RUN_LEN);

   // Status images; unused bits read 0, live bit masked while stuffing
   always_comb begin
      rx_image = '0;
      rx_image[BIT_DENS_EN] = s_q.rx_dens_en;
      rx_image[BIT_ZERO_EN] = s_q.rx_zero_en;
      rx_image[BIT_DENS_EV] = s_q.rx_dens_ev;
      rx_image[BIT_ZERO_EV] = s_q.rx_zero_ev;
      rx_image[BIT_LIVE] = s_q.rx_live && !s_q.tx_stuff_en;
      tx_image = '0;
      tx_image[BIT_DENS_EN] = s_q.tx_dens_en;
      tx_image[BIT_ZERO_EN] = s_q.tx_zero_en;
      tx_image[BIT_DENS_EV] = s_q.tx_dens_ev;
      tx_image[BIT_ZERO_EV] = s_q.tx_zero_ev;
      tx_image[BIT_LIVE] = s_q.tx_live && !s_q.tx_stuff_en;
      tx_image[BIT_FILL_EV] = s_q.tx_fill_ev;
      tx_image[BIT_STUFF_EN] = s_q.tx_stuff_en;
      tx_image[BIT_FILL_EN] = s_q.tx_fill_en;
   end

   // Interrupt sources: each event gated by its own enable; the transmit density event is also masked while fill is enabled
   always_comb begin
      irq_rx = (s_q.rx_dens_ev && s_q.rx_dens_en)
               || (s_q.rx_zero_ev && s_q.rx_zero_en);
      irq_tx = (s_q.tx_dens_ev && s_q.tx_dens_en && !s_q.tx_fill_en)
               || (s_q.tx_zero_ev && s_q.tx_zero_en)
               || (s_q.tx_fill_ev && s_q.tx_fill_en);
   end

   // Next state: clears from reads first, then sets, so a set wins
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;

      // Register reads capture the image before clearing
      if (reg_sel && reg_rd) begin
         s_d.rvalid = 1'b1;
         if (rd_rx) begin
            s_d.rdata = rx_image;
         end else if (rd_tx) begin
            s_d.rdata = tx_image;
         end else begin
            s_d.rdata = UNMAPPED_READ;
         end
      end
      if (rd_rx) begin
         s_d.rx_dens_ev = 1'b0;
         s_d.rx_zero_ev = 1'b0;
      end
      if (rd_tx) begin
         s_d.tx_dens_ev = 1'b0;
         s_d.tx_zero_ev = 1'b0;
         s_d.tx_fill_ev = 1'b0;
      end

      // Register writes to the enable fields
      if (wr_rx) begin
         s_d.rx_dens_en = reg_wdata[BIT_DENS_EN];
         s_d.rx_zero_en = reg_wdata[BIT_ZERO_EN];
      end
      if (wr_tx) begin
         s_d.tx_dens_en = reg_wdata[BIT_DENS_EN];
         s_d.tx_zero_en = reg_wdata[BIT_ZERO_EN];
         s_d.tx_stuff_en = reg_wdata[BIT_STUFF_EN];
         s_d.tx_fill_en = reg_wdata[BIT_FILL_EN];
      end

      // Receive detector; events set regardless of the enables
      if (rx_bit_valid) begin
         s_d.rx_win = rx_next_win;
         s_d.rx_zeros = rx_next_zeros;
         s_d.rx_live = rx_next_live;
         if (rx_next_live != s_q.rx_live) begin
            s_d.rx_dens_ev = 1'b1;
         end
         if (rx_run_hit) begin
            s_d.rx_zero_ev = 1'b1;
         end
      end

      // Output slot empties when the consumer takes the bit
      if (s_q.out_valid && tx_out_ready) begin
         s_d.out_valid = 1'b0;
      end

      // Enforcer: one bit per accepted FIFO word
      if (fifo_valid && tx_take) begin
         s_d.out_bit = tx_bit_sent;
         s_d.out_valid = 1'b1;
         s_d.tx_win = tx_next_win;
         s_d.tx_zeros = tx_next_zeros;
         s_d.tx_live = tx_stuffing ? 1'b0 : tx_next_live;
         if (tx_stuffing) begin
            if (tx_cand_viol) begin
               s_d.tx_fill_ev = 1'b1;
            end
         end else begin
            if (tx_next_live != s_q.tx_live) begin
               s_d.tx_dens_ev = 1'b1;
            end
            if (tx_run_hit) begin
               s_d.tx_zero_ev = 1'b1;
            end
         end
      end

      // Stuffing forces the density and zero-run events low
      if (s_d.tx_stuff_en) begin
         s_d.tx_dens_ev = 1'b0;
         s_d.tx_zero_ev = 1'b0;
         s_d.tx_live = 1'b0;
      end

      // Registered interrupt follows the event bits one cycle later
      s_d.irq = irq_rx || irq_tx;
   end

   // State register; windows start full of ones to avoid a false alarm
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.rx_win <= '1;
         s_q.tx_win <= '1;
         s_q.rx_dens_en <= EN_RESET;
         s_q.rx_zero_en <= EN_RESET;
         s_q.tx_dens_en <= EN_RESET;
         s_q.tx_zero_en <= EN_RESET;
         s_q.tx_fill_en <= EN_RESET;
         s_q.tx_stuff_en <= EN_RESET;
         s_q.rx_dens_ev <= EV_RESET;
         s_q.rx_zero_ev <= EV_RESET;
         s_q.tx_dens_ev <= EV_RESET;
         s_q.tx_zero_ev <= EV_RESET;
         s_q.tx_fill_ev <= EV_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = s_q.rdata;
   assign reg_rdata_valid = s_q.rvalid;
   assign irq_n = !s_q.irq;
   assign tx_out_bit = s_q.out_bit;
   assign tx_out_valid = s_q.out_valid;

endmodule

`default_nettype wire

// file: verification/pdme_properties.sv
// Purpose: Port-level properties of the density monitor and enforcer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Register images are judged in the cycle their valid pulse stands.
`timescale 1ns/1ps
`default_nettype none

module pdme_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire logic reg_sel,
   input wire logic reg_rd,
   input wire logic [pdme_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [pdme_pkg::REG_DATA_W-1:0] reg_rdata,
   input wire logic reg_rdata_valid,
   input wire logic irq_n,
   // Transmit output
   input wire logic tx_out_bit,
   input wire logic tx_out_valid,
   input wire logic tx_out_ready
);
   import pdme_pkg::*;
   logic rx_rd_q;
   logic tx_rd_q;
   // Which register the answered read addressed
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rx_rd_q <= 1'b0;
         tx_rd_q <= 1'b0;
      end else begin
         rx_rd_q <= reg_sel && reg_rd && reg_addr == RX_REG_ADDR;
         tx_rd_q <= reg_sel && reg_rd && reg_addr == TX_REG_ADDR;
      end
   end
   wire logic rx_img = reg_rdata_valid && rx_rd_q;
   wire logic tx_img = reg_rdata_valid && tx_rd_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // An image with an enabled event set means the line was already low, except a transmit density event while fill is enabled
   a_read_answer: assert property (reg_sel && reg_rd |=> reg_rdata_valid)
      else $error("read not answered");
   a_rdata_hold: assert property (!reg_rdata_valid |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_live_stuff: assert property (tx_img && reg_rdata[BIT_STUFF_EN] |-> !reg_rdata[BIT_LIVE])
      else $error("live bit up while stuffing");
   a_stuff_quiet: assert property (tx_img && reg_rdata[BIT_STUFF_EN] |->
      !reg_rdata[BIT_DENS_EV] && !reg_rdata[BIT_ZERO_EV]) else $error("events up while stuffing");
   a_dens_irq: assert property ((rx_img || tx_img && !reg_rdata[BIT_FILL_EN]) &&
      reg_rdata[BIT_DENS_EN] && reg_rdata[BIT_DENS_EV] |-> !irq_n) else $error("no density irq");
   a_zero_irq: assert property ((rx_img || tx_img) && reg_rdata[BIT_ZERO_EN] &&
      reg_rdata[BIT_ZERO_EV] |-> !irq_n) else $error("no zero-run irq");
   a_fill_irq: assert property (tx_img && reg_rdata[BIT_FILL_EN] &&
      reg_rdata[BIT_FILL_EV] |-> !irq_n) else $error("no stuff irq");
   a_reset_quiet: assert property ($fell(reset) |-> irq_n && !reg_rdata_valid && !tx_out_valid)
      else $error("outputs busy after reset");
   a_out_hold: assert property (tx_out_valid && !tx_out_ready |=>
      tx_out_valid && $stable(tx_out_bit)) else $error("output bit dropped");
endmodule

bind pulse_density_monitor_enforcer pdme_properties chk (.core_clk, .reset, .reg_sel,
   .reg_rd, .reg_addr, .reg_rdata, .reg_rdata_valid, .irq_n, .tx_out_bit, .tx_out_valid,
   .tx_out_ready);

`default_nettype wire

// file: verification/pcm_sink.sv
// Purpose: Far-end sink of the enforced PCM stream.
// Assumes: Same clock as the block; ready changes just after an edge.
// Notes: Its window starts full of ones, as the block's does.
`timescale 1ns/1ps
`default_nettype none

module pcm_sink (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Stream from the enforcer
   input wire logic tx_out_bit,
   input wire logic tx_out_valid,
   output logic tx_out_ready,
   // Pacing from the bench
   input wire logic hold,
   input wire logic slow,
   // Observed figures
   output int n_got,
   output int n_viol
);
   logic [23:0] win;
   logic [15:0] rnd;
   // Take bits at a prompt or ragged pace and judge the density
   always @(posedge core_clk) begin
      if (reset) begin
         win <= '1;
         rnd <= 16'h1d2c;
         tx_out_ready <= 1'b0;
         n_got <= 0;
         n_viol <= 0;
      end else begin
         rnd <= {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
         tx_out_ready <= !hold && (!slow || rnd[0]);
         if (tx_out_valid && tx_out_ready) begin
            win <= {win[22:0], tx_out_bit};
            n_got <= n_got + 1;
            if ($countones({win[22:0], tx_out_bit}) < 3) n_viol <= n_viol + 1;
         end
      end
   end
endmodule

`default_nettype wire

// file: verification/tb_pulse_density_monitor_enforcer.sv
// Purpose: Self-checking bench for the density monitor and enforcer.
// Assumes: Inputs change on the falling edge; the sink paces the output.
// Notes: Stuffed streams are judged by the sink, plain ones bit by bit.
`timescale 1ns/1ps
`default_nettype none

module tb_pulse_density_monitor_enforcer;
   import pdme_pkg::*;
   logic core_clk, reset, reg_sel, reg_rd, reg_wr, rx_bit, rx_bit_valid, irq_n;
   logic tx_in_bit, tx_in_valid, tx_in_ready, tx_out_bit, tx_out_valid, tx_out_ready;
   logic reg_rdata_valid, hold, slow, track;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [15:0] rnd;
   logic expq[$];
   int n_fail, checks, sent, cyc, n_got, n_viol, n, v0;

   pulse_density_monitor_enforcer dut (.core_clk, .reset, .reg_sel, .reg_rd, .reg_wr,
      .reg_addr, .reg_wdata, .reg_rdata, .reg_rdata_valid, .irq_n, .rx_bit, .rx_bit_valid,
      .tx_in_bit, .tx_in_valid, .tx_in_ready, .tx_out_bit, .tx_out_valid, .tx_out_ready);
   pcm_sink sink (.core_clk, .reset, .tx_out_bit, .tx_out_valid, .tx_out_ready, .hold,
      .slow, .n_got, .n_viol);

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // Receive image after a violation that also holds a zero run
   function automatic logic [7:0] rx_exp(input int e);
      return 8'(e) | 8'h1c;
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask
   // One register cycle; strobes last a single edge
   task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(negedge core_clk);
      reg_sel = 1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = v;
      @(negedge core_clk);
      d = reg_rdata;
      reg_sel = 0;
      reg_wr = 0;
      reg_rd = 0;
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      acc(0, a, 8'h00);
      chk(d, e, m);
   endtask
   task rxb(input int k, input logic v);
      repeat (k) begin
         @(negedge core_clk);
         rx_bit = v;
         rx_bit_valid = 1;
      end
      @(negedge core_clk);
      rx_bit_valid = 0;
   endtask
   task txp(input logic v);
      @(negedge core_clk);
      tx_in_bit = v;
      tx_in_valid = 1;
      for (int w = 0; w < 50 && !tx_in_ready; w++) @(negedge core_clk);
      if (track) expq.push_back(v);
      sent++;
   endtask
   task drain;
      @(negedge core_clk);
      tx_in_valid = 0;
      for (int w = 0; w < 400 && n_got != sent; w++) @(negedge core_clk);
      chk(8'(n_got - sent), 8'h00, "drained");
      repeat (3) @(negedge core_clk);
   endtask
   task irq(input logic e, input string m);
      chk({7'h00, irq_n}, {7'h00, e}, m);
   endtask
   task done(input string s);
      $display("test %s finished, %0d checks", s, checks);
   endtask
   task end_sim;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   // Cut a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim;
      end
   end
   // Plain stream must leave in the order it entered
   always @(posedge core_clk) begin
      if (tx_out_valid && tx_out_ready && expq.size() > 0) begin
         chk({7'h00, tx_out_bit}, {7'h00, expq.pop_front()}, "out bit");
      end
   end

   initial begin
      {reg_sel, reg_rd, reg_wr, rx_bit, rx_bit_valid, tx_in_bit, tx_in_valid} = '0;
      {reg_addr, reg_wdata} = '0;
      {hold, slow, track} = '0;
      rnd = 16'h85ab;
      reset = 1;
      repeat (10) @(negedge core_clk);
      reset = 0;
      rdc(RX_REG_ADDR, 8'h00, "rx reset");
      rdc(TX_REG_ADDR, 8'h00, "tx reset");
      acc(1, 8'h57, 8'hff);
      rdc(8'h57, UNMAPPED_READ, "unmapped");
      irq(1, "irq idle");
      done("reset");
      // Every enable mix; events must set whatever the enables hold
      for (int e = 3; e >= 0; e--) begin
         acc(1, RX_REG_ADDR, 8'(e));
         rxb(24, 1);
         acc(0, RX_REG_ADDR, 8'h00);
         repeat (2) @(negedge core_clk);
         irq(1, "irq cleared");
         rxb(22, 0);
         repeat (2) @(negedge core_clk);
         irq(e == 0, "irq on events");
         rdc(RX_REG_ADDR, rx_exp(e), "rx events");
         rdc(RX_REG_ADDR, 8'(e) | 8'h10, "rx read clear");
      end
      done("receive");
      // Stalled sink: fill to refusal, then drain at a ragged pace
      acc(1, TX_REG_ADDR, 8'h01);
      hold = 1;
      track = 1;
      repeat (3) @(negedge core_clk);
      n = 0;
      while (n < 20) begin
         @(negedge core_clk);
         if (!tx_in_ready) break;
         rnd = lfsr(rnd);
         tx_in_bit = rnd[0];
         tx_in_valid = 1;
         expq.push_back(rnd[0]);
         n++;
      end
      sent = n;
      tx_in_valid = 0;
      chk(8'(n), 8'(TX_FIFO_DEPTH + 1), "fill depth");
      hold = 0;
      slow = 1;
      repeat (40) begin
         rnd = lfsr(rnd);
         txp(rnd[0]);
      end
      repeat (30) txp(0);
      drain;
      irq(0, "tx density irq");
      rdc(TX_REG_ADDR, 8'h1d, "tx events");
      acc(1, TX_REG_ADDR, 8'h81);
      repeat (24) txp(1);
      drain;
      irq(1, "density irq masked");
      rdc(TX_REG_ADDR, 8'h85, "tx end event");
      done("pass-through");
      // Stuffing on: the sink must never see a thin window
      // Thin windows from the plain phase are expected, so count from here
      track = 0;
      v0 = n_viol;
      acc(1, TX_REG_ADDR, 8'hc0);
      repeat (40) txp(0);
      drain;
      irq(0, "stuff irq");
      rdc(RX_REG_ADDR, 8'h00, "rx live masked");
      rdc(TX_REG_ADDR, 8'he0, "stuff event");
      repeat (2) @(negedge core_clk);
      irq(1, "stuff irq cleared");
      rdc(TX_REG_ADDR, 8'hc0, "stuff cleared");
      chk(8'(n_viol - v0), 8'h00, "thin window");
      done("stuffing");
      end_sim;
   end
endmodule

`default_nettype wire
